// File: src/aeb_pkg.sv
// Shared constants and carrier types of the event buffer readout
package aeb_pkg;
  // Clock, fast clear window and broadcast decode timing
  localparam int unsigned CLK_MHZ      = 10;
  localparam int unsigned FCW_STEP_NS  = 2000;
  localparam int unsigned FCW_STEP_CYC = (FCW_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0]  DEC_CYC      = 2'h2;
  // Register offsets in control space
  localparam logic [31:0] A_CTRL = 32'h0000_0000;
  localparam logic [31:0] A_ACQ  = 32'h0000_0001;
  localparam logic [31:0] A_LA   = 32'h0000_0003;
  localparam logic [31:0] A_WCNT = 32'h0000_0005;
  localparam logic [31:0] A_BCLS = 32'h0000_0007;
  localparam logic [31:0] A_BPTR = 32'h0000_0010;
  localparam logic [31:0] A_THR  = 32'hC000_0000;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h104F_0000;
  localparam logic [31:0] ACQ_RST  = 32'h0000_0040;
  localparam logic [5:0]  RD_RST   = 6'h3F;
  localparam logic [5:0]  WR_RST   = 6'h00;
  // Field positions
  localparam int unsigned CB_FCLR   = 31;
  localparam int unsigned CB_MRST   = 30;
  localparam int unsigned CB_LNE    = 10;
  localparam int unsigned CB_MTM    = 3;
  localparam int unsigned CB_GATE   = 2;
  localparam int unsigned CB_LAEN   = 0;
  localparam logic [31:0] CTRL_PULSE = 32'hC000_0400;
  localparam int unsigned ST_FULL   = 13;
  localparam int unsigned ST_EMPTY  = 14;
  localparam int unsigned AB_SPARSE = 22;
  localparam int unsigned AB_FCW_LO = 24;
  localparam int unsigned PAR_BIT   = 26;
  // Broadcast codes, low address byte
  localparam logic [7:0] BC_GEN   = 8'h01;
  localparam logic [7:0] BC_CLS   = 8'h05;
  localparam logic [7:0] BC_SDS   = 8'h09;
  localparam logic [7:0] BC_SDS_E = 8'h19;
  localparam logic [7:0] BC_ALL   = 8'h0D;
  localparam logic [7:0] BC_SDS_B = 8'hBD;
  localparam logic [7:0] BC_UNSUP = 8'hCD;
  // Slave status answers
  localparam logic [2:0] SS_OK  = 3'h0;
  localparam logic [2:0] SS_END = 3'h2;
  // Backplane pins and conversion words
  typedef struct packed {
    logic        as;
    logic        ds;
    logic        wr;
    logic        ctl;
    logic        eg;
    logic        bc;
    logic        blk;
    logic        sa;
    logic        gate;
    logic        fclr;
    logic [4:0]  slot;
    logic [31:0] ad;
  } aeb_pins_t;
  typedef struct packed {
    logic        last;
    logic [5:0]  chan;
    logic [12:0] q;
  } aeb_conv_t;
endpackage : aeb_pkg

// File: src/aeb_event_buffer.sv
// Event buffer, threshold suppression and backplane slave readout
// Summary of operation
// - Drop conversions below channel threshold
// - Store raw value, threshold not subtracted
// - Thresholds 13 bits, upper bits zero
// - Thresholds survive power-up and master reset
// - Top two threshold bits set disable channel
// - Answer logical address in both spaces
// - Answer geographic address in both spaces
// - Join general and own-class broadcasts
// - Scan codes drive T-pin on data state
// - Unconditional, vendor and unsuppressed scans
// - Class register picks classes three to zero
// - Hold WAIT while decoding a broadcast
// - Memory is 64 pages of 128 words
// - Reset leaves test mode off, NTA ignored
// - Reset pointers: read 63, write 0
// - Test mode addresses selected page directly
// - Empty at rd=wr-1, full at rd=wr
// - Header word holds count, buffer, address, parity
// - Data word holds charge, channel, address, parity
// - Load next event then counted block read
// - Random data writes only, no block writes
// - Fast clear in window drops the event
// - Window starts at gate end, timed by config
module aeb_fifo #(
  parameter int unsigned W     = 20,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] ram [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  logic          push;
  logic          pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_o = ram[rp];

  always_ff @(posedge clk_i)
  begin
    if (push)
      ram[wp] <= in_data_i;
  end

  // Flags are registered so the fill side sees a clean ready
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (push)
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      if (pop)
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      cnt <= next_cnt;
      in_ready_o <= next_cnt != (AW+1)'(DEPTH);
      out_valid_o <= next_cnt != '0;
    end
  end
endmodule : aeb_fifo

module aeb_event_buffer
  import aeb_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      rst_b_i,
  // Backplane pins
  input  wire aeb_pins_t pins_i,
  output logic [31:0]    bus_ad_o,
  output logic           bus_ad_oe_o,
  output logic           bus_ak_o,
  output logic           bus_dk_o,
  output logic [2:0]     bus_ss_o,
  output logic           bus_wait_o,
  output logic           bus_tpin_o,
  // Conversion stream and hold-off
  input  wire logic      conv_valid_i,
  input  wire aeb_conv_t conv_i,
  output logic           conv_ready_o,
  output logic           cip_o
);
  typedef enum logic [1:0] {A_IDLE, A_DEC, A_CONN} aeb_astate_t;
  typedef enum logic {E_IDLE, E_FILL} aeb_estate_t;

  aeb_pins_t   meta;
  aeb_pins_t   pin;
  logic        as_d, ds_d, gate_d;
  aeb_astate_t ast;
  aeb_estate_t est;
  logic [31:0] main_control_reg, acq_reg, adr_q, csr_nta, rdata;
  logic [15:0] logical_address_reg;
  logic [6:0]  word_count_reg, d_nta, rd_wd, ev_wd;
  logic [3:0]  broadcast_class_reg;
  logic [5:0]  rd_pg, wr_pg;
  logic [12:0] thr [64];
  logic [31:0] mem [8192];
  logic [1:0]  dec_cnt;
  logic [15:0] fcw_cnt;
  logic        conn_bc, bc_live, tp_arm, tp_val, mr_q, lne_q;
  logic        ev_done, ev_clr;
  logic        as_rise, as_fall, gate_fall, dchg, dcyc, cw, cr, dw, dr;
  logic        full, empty, memory_test_mode, thr_hit, load_next_event, fclr, bus_we;
  logic        fo_valid, pop, keep, dis, commit, ev_we;
  aeb_conv_t   fo;
  logic [4:0]  modaddr;
  logic [12:0] addr_ma;
  logic [31:0] mem_rd, hdr_next, ev_data;
  logic [7:0]  code;

  function automatic logic [31:0] mk_word(input logic [4:0]  a,
                                          input logic [1:0]  b,
                                          input logic [23:0] body);
    logic [31:0] w;
    w = {a, 1'b0, b, body};
    w[PAR_BIT] = ^w;
    return w;
  endfunction : mk_word

  // Two stages before any logic sees the backplane pins
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta <= '0;
      pin <= '0;
      as_d <= 1'b0;
      ds_d <= 1'b0;
      gate_d <= 1'b0;
    end
    else
    begin
      meta <= pins_i;
      pin <= meta;
      as_d <= pin.as;
      ds_d <= pin.ds;
      gate_d <= pin.gate;
    end
  end

  assign as_rise = pin.as & ~as_d;
  assign as_fall = ~pin.as & as_d;
  assign gate_fall = ~pin.gate & gate_d;
  assign dchg = (ast == A_CONN) & (pin.ds ^ ds_d);
  assign dcyc = dchg & (bc_live | ~conn_bc);
  assign cw = dcyc & pin.ctl & pin.wr & ~pin.sa;
  assign cr = dcyc & pin.ctl & ~pin.wr & ~conn_bc;
  assign dw = dcyc & ~pin.ctl & pin.wr & ~pin.sa & ~pin.blk;
  assign dr = dcyc & ~pin.ctl & ~pin.wr & ~conn_bc;
  assign memory_test_mode = main_control_reg[CB_MTM];
  assign full = rd_pg == wr_pg;
  assign empty = rd_pg == wr_pg - 6'h01;
  assign thr_hit = csr_nta[31:6] == A_THR[31:6];
  assign load_next_event = cw & (csr_nta == A_CTRL) & pin.ad[CB_LNE];
  assign fclr = pin.fclr | (cw & (csr_nta == A_CTRL) & pin.ad[CB_FCLR]);
  assign addr_ma = {rd_pg, memory_test_mode ? d_nta : rd_wd};
  assign mem_rd = mem[addr_ma];
  assign hdr_next = mem[{rd_pg + 6'h01, 7'h00}];
  assign bus_we = dw;
  assign code = adr_q[7:0];
  assign modaddr = main_control_reg[CB_LAEN] ?
                   logical_address_reg[4:0] : pin.slot;

  // Control registers; master reset spares address and class
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      main_control_reg <= CTRL_RST;
      acq_reg <= ACQ_RST;
      logical_address_reg <= '0;
      broadcast_class_reg <= '0;
      mr_q <= 1'b0;
    end
    else
    begin
      mr_q <= cw & (csr_nta == A_CTRL) & pin.ad[CB_MRST];
      if (mr_q)
      begin
        main_control_reg <= CTRL_RST;
        acq_reg <= ACQ_RST;
      end
      else if (cw)
      begin
        if (csr_nta == A_CTRL)
          main_control_reg <= pin.ad & ~CTRL_PULSE;
        if (csr_nta == A_ACQ)
          acq_reg <= pin.ad;
        if (csr_nta == A_LA)
          logical_address_reg <= pin.ad[31:16];
        if (csr_nta == A_BCLS)
          broadcast_class_reg <= pin.ad[3:0];
      end
    end
  end

  // No reset: thresholds outlive power-up and master reset
  always_ff @(posedge ref_clk_i)
  begin
    if (cw & thr_hit)
      thr[csr_nta[5:0]] <= pin.ad[12:0];
  end

  // Buffer pointers
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_pg <= RD_RST;
      wr_pg <= WR_RST;
      lne_q <= 1'b0;
    end
    else
    begin
      lne_q <= load_next_event & ~mr_q;
      if (mr_q)
      begin
        rd_pg <= RD_RST;
        wr_pg <= WR_RST;
      end
      else if (cw & (csr_nta == A_BPTR))
      begin
        rd_pg <= pin.ad[13:8];
        wr_pg <= pin.ad[5:0];
      end
      else
      begin
        if (load_next_event)
          rd_pg <= rd_pg + 6'h01;
        if (commit & ~ev_clr)
          wr_pg <= wr_pg + 6'h01;
      end
    end
  end

  // Word count and read position inside the page
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      word_count_reg <= '0;
      rd_wd <= '0;
      d_nta <= '0;
    end
    else if (mr_q)
    begin
      word_count_reg <= '0;
      rd_wd <= '0;
      d_nta <= '0;
    end
    else
    begin
      if (lne_q)
      begin
        word_count_reg <= mem[{rd_pg, 7'h00}][6:0];
        rd_wd <= '0;
      end
      else if (cw & (csr_nta == A_WCNT))
        word_count_reg <= pin.ad[6:0];
      else if (dr & ~memory_test_mode & pin.blk & (word_count_reg != '0))
        word_count_reg <= word_count_reg - 7'h01;
      if (!lne_q & ~memory_test_mode & (dw | (dr & ~(pin.blk &
          (word_count_reg == '0)))))
        rd_wd <= rd_wd + 7'h01;
      if (dcyc & pin.sa & pin.wr & ~pin.ctl & memory_test_mode)
        d_nta <= pin.ad[6:0];
    end
  end

  // Address cycle: match, broadcast decode and disconnect
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ast <= A_IDLE;
      adr_q <= '0;
      dec_cnt <= '0;
      conn_bc <= 1'b0;
      bc_live <= 1'b0;
      tp_arm <= 1'b0;
      tp_val <= 1'b0;
      csr_nta <= '0;
      bus_ak_o <= 1'b0;
      bus_wait_o <= 1'b0;
    end
    else if (as_fall)
    begin
      ast <= A_IDLE;
      bus_ak_o <= 1'b0;
      bus_wait_o <= 1'b0;
      csr_nta <= '0;
      tp_arm <= 1'b0;
    end
    else
    begin
      unique case (ast)
        A_IDLE:
        begin
          if (as_rise)
          begin
            adr_q <= pin.ad;
            conn_bc <= pin.bc;
            if (pin.bc)
            begin
              ast <= A_DEC;
              dec_cnt <= DEC_CYC;
              bus_wait_o <= 1'b1;
            end
            else if ((pin.eg & (pin.ad[4:0] == pin.slot)) |
                     (~pin.eg & main_control_reg[CB_LAEN] &
                      (pin.ad[31:16] == logical_address_reg)))
            begin
              ast <= A_CONN;
              bus_ak_o <= 1'b1;
            end
          end
        end
        A_DEC:
        begin
          dec_cnt <= dec_cnt - 2'h1;
          if (dec_cnt == 2'h1)
          begin
            ast <= A_CONN;
            bus_wait_o <= 1'b0;
            bc_live <= (code == BC_GEN) | ((code == BC_CLS) &
                       ~adr_q[10] & broadcast_class_reg[adr_q[9:8]]);
            tp_arm <= (code == BC_SDS) | (code == BC_SDS_E) |
                      (code == BC_ALL) | (code == BC_SDS_B) |
                      (code == BC_UNSUP);
            unique case (code)
              BC_SDS, BC_SDS_B: tp_val <= ~empty;
              BC_SDS_E:         tp_val <= empty;
              BC_ALL:           tp_val <= 1'b1;
              default:          tp_val <= ~empty &
                                          (hdr_next[6:0] > 7'h01);
            endcase
          end
        end
        A_CONN:
        begin
          if (dcyc & pin.sa & pin.wr & pin.ctl)
            csr_nta <= pin.ad;
        end
        default:
          ast <= A_IDLE;
      endcase
    end
  end

  // Control space read mux; unmapped offsets read zero
  always_comb
  begin
    rdata = '0;
    if (thr_hit)
      rdata = {19'h0, thr[csr_nta[5:0]]};
    else if (csr_nta == A_CTRL)
    begin
      rdata = main_control_reg;
      rdata[ST_FULL] = full;
      rdata[ST_EMPTY] = empty;
    end
    else if (csr_nta == A_ACQ)
      rdata = acq_reg;
    else if (csr_nta == A_LA)
      rdata = {logical_address_reg, 16'h0};
    else if (csr_nta == A_WCNT)
      rdata = {25'h0, word_count_reg};
    else if (csr_nta == A_BCLS)
      rdata = {28'h0, broadcast_class_reg};
    else if (csr_nta == A_BPTR)
      rdata = {18'h0, rd_pg, 2'h0, wr_pg};
  end

  // Data cycle answers; broadcasts are never acknowledged
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bus_ad_o <= '0;
      bus_ad_oe_o <= 1'b0;
      bus_dk_o <= 1'b0;
      bus_ss_o <= SS_OK;
      bus_tpin_o <= 1'b0;
    end
    else if (as_fall)
    begin
      bus_ad_oe_o <= 1'b0;
      bus_dk_o <= 1'b0;
      bus_ss_o <= SS_OK;
      bus_tpin_o <= 1'b0;
    end
    else if (dcyc | (dchg & conn_bc))
    begin
      if (conn_bc)
        bus_tpin_o <= tp_arm & tp_val & ~pin.wr;
      else
      begin
        bus_dk_o <= pin.ds;
        bus_ad_oe_o <= ~pin.wr;
        bus_ss_o <= SS_OK;
        if (cr)
          bus_ad_o <= rdata;
        else if (dr)
        begin
          if (~memory_test_mode & pin.blk & (word_count_reg == '0))
            bus_ss_o <= SS_END;
          else
            bus_ad_o <= mem_rd;
        end
        else if (~pin.ctl & pin.wr & ~pin.sa & pin.blk)
          bus_ss_o <= SS_END;
      end
    end
  end

  // Conversion words queue here while the page is unavailable
  aeb_fifo #(
    .W     ($bits(aeb_conv_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (conv_valid_i),
    .in_ready_o  (conv_ready_o),
    .in_data_i   (conv_i),
    .out_valid_o (fo_valid),
    .out_ready_i (pop),
    .out_data_o  (fo)
  );

  // Full stalls the drain so the queue fills and holds the front end
  assign pop = (est == E_FILL) & fo_valid & ~ev_done & ~full & ~bus_we;
  assign dis = &thr[fo.chan][12:11];
  assign keep = ~dis & ~(acq_reg[AB_SPARSE] & (fo.q < thr[fo.chan]));
  assign commit = (est == E_FILL) & ev_done & (fcw_cnt == '0) &
                  ~full & ~bus_we;
  assign ev_we = (pop & keep) | (commit & ~ev_clr);
  assign ev_data = pop ?
    mk_word(modaddr, wr_pg[1:0], {1'b0, fo.chan, 4'h0, fo.q}) :
    mk_word(modaddr, wr_pg[1:0], {10'h0, wr_pg, 1'b0, ev_wd});

  // One page per event, header written last at word zero
  always_ff @(posedge ref_clk_i)
  begin
    if (bus_we)
      mem[addr_ma] <= pin.ad;
    else if (ev_we)
      mem[{wr_pg, pop ? ev_wd : 7'h00}] <= ev_data;
  end

  // Event manager with fast clear window
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      est <= E_IDLE;
      ev_wd <= 7'h01;
      fcw_cnt <= '0;
      ev_done <= 1'b0;
      ev_clr <= 1'b0;
      cip_o <= 1'b0;
    end
    else if (mr_q)
    begin
      est <= E_IDLE;
      ev_done <= 1'b0;
      ev_clr <= 1'b0;
      fcw_cnt <= '0;
      cip_o <= 1'b0;
    end
    else
    begin
      cip_o <= (est != E_IDLE) | full;
      unique case (est)
        E_IDLE:
        begin
          if (gate_fall & main_control_reg[CB_GATE])
          begin
            est <= E_FILL;
            ev_wd <= 7'h01;
            ev_done <= 1'b0;
            ev_clr <= 1'b0;
            fcw_cnt <= 16'((acq_reg[AB_FCW_LO+3:AB_FCW_LO] + 32'h1) *
                           FCW_STEP_CYC);
          end
        end
        E_FILL:
        begin
          if (fcw_cnt != '0)
            fcw_cnt <= fcw_cnt - 16'h1;
          if (fclr & (fcw_cnt != '0))
            ev_clr <= 1'b1;
          if (pop & keep)
            ev_wd <= ev_wd + 7'h01;
          if (pop & fo.last)
            ev_done <= 1'b1;
          if (commit)
            est <= E_IDLE;
        end
      endcase
    end
  end

  property p_thr_drop;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (pop & acq_reg[AB_SPARSE] & (fo.q < thr[fo.chan])) |=> $stable(ev_wd);
  endproperty
  a_thr_drop: assert property (p_thr_drop) else $error("below");

  property p_raw;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (pop & keep) |-> (ev_data[12:0] == fo.q) && (ev_data[22:17] == fo.chan);
  endproperty
  a_raw: assert property (p_raw) else $error("raw data altered");

  property p_dis;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (pop & (&thr[fo.chan][12:11])) |-> !ev_we;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled stored");

  property p_wait;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (ast == A_IDLE & as_rise & pin.bc) |=> bus_wait_o ##1 bus_wait_o
      ##1 !bus_wait_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait shape");

  property p_lne;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (load_next_event & ~mr_q & ~pin.ad[CB_MRST]) |=>
      (rd_pg == $past(rd_pg) + 6'h01) ##1
      (word_count_reg == mem[{rd_pg, 7'h00}][6:0]);
  endproperty
  a_lne: assert property (p_lne) else $error("lne load");

  property p_blk_end;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (dr & ~memory_test_mode & pin.blk & (word_count_reg == '0) & ~as_fall) |=>
      (bus_ss_o == SS_END);
  endproperty
  a_blk_end: assert property (p_blk_end) else $error("no end");

  property p_full;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (full & ~mr_q & ~(cw & (csr_nta == A_BPTR))) |=>
      $stable(wr_pg);
  endproperty
  a_full: assert property (p_full) else $error("stored full");

  property p_fclr;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (commit & ev_clr & ~mr_q & ~cw) |=> (wr_pg == $past(wr_pg));
  endproperty
  a_fclr: assert property (p_fclr) else $error("clear moved");

  property p_mreset;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    mr_q |=> (rd_pg == RD_RST) && (wr_pg == WR_RST) && !memory_test_mode;
  endproperty
  a_mreset: assert property (p_mreset) else $error("reset ptrs");

  property p_nta;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (dcyc & pin.sa & pin.wr & ~pin.ctl & ~memory_test_mode & ~mr_q) |=> $stable(d_nta);
  endproperty
  a_nta: assert property (p_nta) else $error("nta moved");
endmodule : aeb_event_buffer

// File: tb/aeb_master.sv
// Crate master model driving the slave's backplane pins
module aeb_master
  import aeb_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Pins into the slave
  output aeb_pins_t        pins_o,
  // Slave answers
  input  wire logic [31:0] ad_i,
  input  wire logic        ak_i,
  input  wire logic        dk_i,
  input  wire logic [2:0]  ss_i,
  input  wire logic        tpin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int n;
  initial
  begin
    pins_o      = '0;
    pins_o.slot = 5'h0B;
  end
  task automatic tick(input int k);
    repeat (k) @(negedge clk_i);
  endtask : tick
  // Mode is {eg, ctl, bc, blk}; the wait for the ack is bounded
  task automatic attach(input logic [3:0] m, input logic [31:0] a,
                        output logic k);
    tick(1);
    {pins_o.eg, pins_o.ctl, pins_o.bc, pins_o.blk} = m;
    pins_o.ad = a;
    pins_o.as = 1'b1;
    for (n = 0; n < 10 && ak_i !== 1'b1; n++)
      tick(1);
    k = ak_i;
  endtask : attach
  // Qualifiers settle 3 cycles before the strobe and stay after it
  task automatic xfer(input logic wr, input logic sa, input logic [31:0] d,
                      output logic [31:0] q, output logic [2:0] s,
                      output logic t);
    tick(1);
    pins_o.wr = wr;
    pins_o.sa = sa;
    pins_o.ad = wr ? d : ~pins_o.ad; // Released lines keep no old data
    tick(3);
    pins_o.ds = ~pins_o.ds;
    // The answer takes 3 cycles; a stale dk may already match
    for (n = 0; n < 12 && (n < 3 || dk_i !== pins_o.ds); n++)
      tick(1);
    q = ad_i;
    s = ss_i;
    t = tpin_i;
    tick(2);
  endtask : xfer
  task automatic detach();
    tick(1);
    pins_o.as = 1'b0;
    pins_o.ad = ~pins_o.ad;
    tick(5);
  endtask : detach
  // Front panel gate and fast clear levels
  task automatic front(input logic g, input logic f);
    tick(1);
    pins_o.gate = g;
    pins_o.fclr = f;
  endtask : front
endmodule : aeb_master

// File: tb/aeb_event_buffer_test.sv
// Self-checking bench for the event buffer readout
module aeb_event_buffer_test
  import aeb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] GC = 4'hC;
  logic        clk;
  logic        rst_b;
  aeb_pins_t   pins;
  logic [31:0] ad;
  logic        ak;
  logic        dk;
  logic [2:0]  ss;
  logic        tp;
  logic        cv_valid;
  aeb_conv_t   cv;
  logic        cv_ready;
  logic        oe;
  logic        wt;
  logic        conversion_in_progress;
  logic [31:0] q;
  logic [31:0] ga;
  logic [2:0]  s;
  logic        t;
  logic        k;
  int          errors;
  int          n_checks;
  int          cyc;
  int          n_wait;
  assign ga = {27'h0, pins.slot};
  aeb_event_buffer dut_u (
    .ref_clk_i    (clk),
    .rst_b_i      (rst_b),
    .pins_i       (pins),
    .bus_ad_o     (ad),
    .bus_ad_oe_o  (oe),
    .bus_ak_o     (ak),
    .bus_dk_o     (dk),
    .bus_ss_o     (ss),
    .bus_wait_o   (wt),
    .bus_tpin_o   (tp),
    .conv_valid_i (cv_valid),
    .conv_i       (cv),
    .conv_ready_o (cv_ready),
    .cip_o        (conversion_in_progress)
  );
  aeb_master m_u (
    .clk_i  (clk),
    .pins_o (pins),
    .ad_i   (ad),
    .ak_i   (ak),
    .dk_i   (dk),
    .ss_i   (ss),
    .tpin_i (tp)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk)
    if (wt === 1'b1)
      n_wait++;
  // The whole run needs under two thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Control access: secondary address, then one data cycle
  task automatic cs(input logic [3:0] m, input logic [31:0] pa,
                    input logic wr, input logic [31:0] a,
                    input logic [31:0] d);
    m_u.attach(m, pa, k);
    m_u.xfer(1'b1, 1'b1, a, q, s, t);
    m_u.xfer(wr, 1'b0, d, q, s, t);
    m_u.detach();
  endtask : cs
  // Valid stays up between words so it never toggles in one step
  task automatic put(input logic l, input logic [5:0] c,
                     input logic [12:0] v);
    cv = {l, c, v};
    cv_valid = 1'b1;
    for (int i = 0; i < 50 && cv_ready !== 1'b1; i++)
      @(negedge clk);
    @(negedge clk);
  endtask : put
  // Ch0 under threshold, ch1 kept, ch2 disabled at full scale
  task automatic event_in(input logic fc);
    m_u.front(1'b1, 1'b0);
    m_u.front(1'b0, 1'b0);
    put(1'b0, 6'd0, 13'd50);
    put(1'b0, 6'd1, 13'd200);
    put(1'b1, 6'd2, 13'h1FFF);
    cv_valid = 1'b0;
    m_u.front(1'b0, fc);
    m_u.front(1'b0, 1'b0);
    m_u.tick(60);
  endtask : event_in
  task automatic t_scan();
    logic [7:0] c [5] = '{BC_SDS, BC_SDS_E, BC_ALL, BC_SDS_B, BC_UNSUP};
    logic       e [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++)
    begin
      m_u.attach(4'h6, {24'h0, c[i]}, k);
      m_u.xfer(1'b0, 1'b0, 32'h0, q, s, t);
      m_u.detach();
      check("tpin", 32'(t), 32'(e[i]));
    end
    check("wait", 32'(n_wait), 32'h0000_000A);
    $display("t_scan done");
  endtask : t_scan
  task automatic t_regs();
    cs(GC, ga, 1'b1, A_THR + 2, 32'hFFFF_FFFF);
    cs(GC, ga, 1'b1, 32'h0000_0020, 32'hFFFF_FFFF);
    cs(GC, ga, 1'b1, A_WCNT, 32'h0000_0033);
    cs(GC, ga, 1'b1, A_CTRL, 32'h4000_0000);
    cs(GC, ga, 1'b0, A_THR + 2, 32'h0);
    check("thr", q, 32'h0000_1FFF);
    cs(GC, ga, 1'b0, 32'h0000_0020, 32'h0);
    check("unmapped", q, 32'h0);
    cs(GC, ga, 1'b0, A_WCNT, 32'h0);
    check("wcnt", q, 32'h0);
    cs(GC, ga, 1'b0, A_BPTR, 32'h0);
    check("bptr", q, 32'h0000_3F00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_addr();
    cs(GC, ga, 1'b1, A_LA, 32'h00A5_0000);
    cs(GC, ga, 1'b1, A_CTRL, 32'h0000_0005);
    cs(GC, ga, 1'b1, A_BCLS, 32'h0000_0004);
    m_u.attach(4'h4, 32'h00A6_0000, k);
    m_u.detach();
    check("ak", 32'(k), 32'h0);
    cs(4'h6, 32'h0000_0001, 1'b1, A_WCNT, 32'h0000_0033);
    cs(4'h4, 32'h00A5_0000, 1'b0, A_WCNT, 32'h0);
    check("general", q, 32'h0000_0033);
    cs(4'h6, 32'h0000_0205, 1'b1, A_WCNT, 32'h0000_0011);
    cs(4'h6, 32'h0000_0105, 1'b1, A_WCNT, 32'h0000_0022);
    cs(GC, ga, 1'b0, A_WCNT, 32'h0);
    check("class", q, 32'h0000_0011);
    cs(GC, ga, 1'b1, A_CTRL, 32'h0000_0004);
    $display("t_addr done");
  endtask : t_addr
  // Second event is cleared in its window; words assume slot 0x0B
  task automatic t_event();
    logic [31:0] w [2] = '{32'h5800_0002, 32'h5C02_00C8};
    cs(GC, ga, 1'b1, A_ACQ, 32'h0040_0040);
    cs(GC, ga, 1'b1, A_THR, 32'd100);
    cs(GC, ga, 1'b1, A_THR + 1, 32'd100);
    event_in(1'b0);
    event_in(1'b1);
    cs(GC, ga, 1'b0, A_BPTR, 32'h0);
    check("bptr", q, 32'h0000_3F01);
    cs(GC, ga, 1'b1, A_CTRL, 32'h0000_0404);
    cs(GC, ga, 1'b0, A_WCNT, 32'h0);
    check("wcnt", q, 32'h0000_0002);
    m_u.attach(4'h9, ga, k);
    for (int i = 0; i < 3; i++)
    begin
      m_u.xfer(1'b0, 1'b0, 32'h0, q, s, t);
      check("ss", 32'(s), (i < 2) ? 32'(SS_OK) : 32'(SS_END));
      check("oe", 32'(oe), 32'h0000_0001);
      if (i < 2)
        check("word", q, w[i]);
    end
    m_u.detach();
    m_u.attach(4'h9, ga, k);
    m_u.xfer(1'b1, 1'b0, 32'h1, q, s, t);
    m_u.detach();
    check("blk wr", 32'(s), 32'(SS_END));
    $display("t_event done");
  endtask : t_event
  // Test mode reads page 0 word 1; full pointers hold the next event
  task automatic t_page();
    cs(GC, ga, 1'b1, A_CTRL, 32'h0000_000C);
    m_u.attach(4'h8, ga, k);
    m_u.xfer(1'b1, 1'b1, 32'h0000_0001, q, s, t);
    m_u.detach();
    cs(GC, ga, 1'b1, A_CTRL, 32'h0000_0004);
    m_u.attach(4'h8, ga, k);
    m_u.xfer(1'b1, 1'b1, 32'h0000_0000, q, s, t);
    m_u.detach();
    cs(GC, ga, 1'b1, A_CTRL, 32'h0000_000C);
    m_u.attach(4'h8, ga, k);
    m_u.xfer(1'b0, 1'b0, 32'h0000_0000, q, s, t);
    m_u.detach();
    check("mtm", q, 32'h5C02_00C8);
    cs(GC, ga, 1'b1, A_CTRL, 32'h0000_0004);
    check("cip", 32'(conversion_in_progress), 32'h0000_0000);
    cs(GC, ga, 1'b1, A_BPTR, 32'h0000_0101);
    event_in(1'b0);
    cs(GC, ga, 1'b0, A_BPTR, 32'h0);
    check("full", q, 32'h0000_0101);
    check("cip", 32'(conversion_in_progress), 32'h0000_0001);
    $display("t_page done");
  endtask : t_page
  initial
  begin
    rst_b = 1'b0;
    cv_valid = 1'b0;
    cv = '0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    m_u.tick(2);
    t_scan();
    t_regs();
    t_addr();
    t_event();
    t_page();
    end_sim();
  end
endmodule : aeb_event_buffer_test
